/* src/mwd_pkg.sv */
// constants shared by the motion-wake detect configuration block
package mwd_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] MWD_ADDR_SHADOW_DATA = 8'h13;
  localparam logic [7:0] MWD_ADDR_CONFIG      = 8'h14;
  localparam logic [7:0] MWD_CONFIG_RESET     = 8'h00;
  localparam logic [7:0] MWD_READ_UNMAPPED    = 8'h00;

  // ----------------------------------------------------------------
  // fields of motion_wake_config
  // ----------------------------------------------------------------
  localparam int MWD_SEL_LSB    = 0;
  localparam int MWD_SEL_MSB    = 2;
  localparam int MWD_CNTEN_BIT  = 3;
  localparam int MWD_WIN_LSB    = 4;
  localparam int MWD_WIN_MSB    = 6;
  localparam int MWD_DETRST_BIT = 7;

  // ----------------------------------------------------------------
  // widths and codes
  // ----------------------------------------------------------------
  localparam int MWD_SAMPLE_W = 12;
  localparam int MWD_DELTA_W  = 11;
  localparam int MWD_THR_W    = 6;
  localparam int MWD_AXES     = 3;
  localparam int MWD_SHADOWS  = 6;
  localparam logic [2:0] MWD_WIN_MAX     = 3'h5;
  localparam logic [5:0] MWD_SLICE_CLAMP = 6'h3f;
  localparam logic [5:0] MWD_SHADOW_RST  = 6'h00;
  localparam logic [2:0] MWD_IDX_COUNT_BASE = 3'h3;
endpackage

/* src/mwd_shadow_bank.sv */
// six 6-bit shadow registers: thresholds and detection counts per axis
`timescale 1ns/1ps
module mwd_shadow_bank
  import mwd_pkg::*;
(
  input  wire logic                               i_sys_clk,
  input  wire logic                               i_sys_rst,
  input  wire logic                               i_wr,
  input  wire logic [2:0]                         i_idx,
  input  wire logic [MWD_THR_W-1:0]               i_wdata,
  output logic      [MWD_THR_W-1:0]               o_rdata,
  output logic      [MWD_SHADOWS*MWD_THR_W-1:0]   o_all
);
  logic [MWD_THR_W-1:0] mem_q [MWD_SHADOWS];

  genvar g;
  generate
    for (g = 0; g < MWD_SHADOWS; g++) begin : g_ent
      always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          mem_q[g] <= MWD_SHADOW_RST;
        end else if (i_wr && (i_idx == 3'(g))) begin
          mem_q[g] <= i_wdata;
        end
      end
      assign o_all[g*MWD_THR_W +: MWD_THR_W] = mem_q[g];
    end
  endgenerate

  // read data from a register; follows the index one cycle late
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rdata <= MWD_SHADOW_RST;
    end else if (i_idx < 3'(MWD_SHADOWS)) begin
      o_rdata <= mem_q[i_idx];
    end else begin
      o_rdata <= MWD_SHADOW_RST;
    end
  end
endmodule

/* src/mwd_motion_wake.sv */
// motion-wake detector: configuration register, shadow access, per-axis compare
`timescale 1ns/1ps

// Overview of operation
// - the selector in config bits [2:0] routes the shadow data register to X/Y/Z thresholds (001-011), X/Y/Z counts (101-111), or nothing (000, 100).
// - config bit 3 turns the detection counters of all three axes on or off together.
// - config bits [6:4] pick the six-bit window of the 11-bit delta, from [5:0] at 000 up to [10:5] at 101 and above.
// - any delta bit set above the chosen window saturates the compared slice to 63, so the event counts unless the threshold is 63.
// - writing 1 to config bit 7 pulses a detector reset that clears itself, used to re-arm after an event.
// - each axis threshold is an independent unsigned 6-bit value 0 to 63.
// - each axis count register holds the wanted number of events minus one, for 1 to 64 events.
// - each axis delta is taken between the current sample and the one just before it.
module mwd_motion_wake
  import mwd_pkg::*;
(
  input  wire logic                                i_sys_clk,
  input  wire logic                                i_sys_rst,
  input  wire logic [7:0]                          i_reg_addr,
  input  wire logic                                i_reg_wr,
  input  wire logic                                i_reg_rd,
  input  wire logic [7:0]                          i_reg_wdata,
  output logic      [7:0]                          o_reg_rdata,
  input  wire logic                                i_sample_valid,
  input  wire logic [MWD_AXES*MWD_SAMPLE_W-1:0]    i_sample,
  output logic      [MWD_AXES-1:0]                 o_axis_wake,
  output logic                                     o_detect_count_enable,
  output logic                                     o_detector_reset
);
  // ----------------------------------------------------------------
  // configuration register
  // ----------------------------------------------------------------
  logic [6:0] cfg_q;
  logic       det_rst_q;
  logic       hit_cfg;
  logic       hit_shadow;
  logic       wr_cfg;
  logic       wr_shadow;
  logic       wr_det_rst;

  assign hit_cfg    = (i_reg_addr == MWD_ADDR_CONFIG);
  assign hit_shadow = (i_reg_addr == MWD_ADDR_SHADOW_DATA);
  assign wr_cfg     = i_reg_wr && hit_cfg;
  assign wr_shadow  = i_reg_wr && hit_shadow;
  // bit 7 is a command, not state: it never lands in cfg_q
  assign wr_det_rst = wr_cfg && i_reg_wdata[MWD_DETRST_BIT];

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cfg_q <= MWD_CONFIG_RESET[6:0];
    end else if (wr_cfg) begin
      cfg_q <= i_reg_wdata[6:0];
    end
  end

  // self-clearing: high for exactly one cycle per write of a one
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      det_rst_q <= 1'b0;
    end else begin
      det_rst_q <= wr_det_rst;
    end
  end

  logic [2:0] shadow_sel;
  logic       cnt_en;
  logic [2:0] win_sel;
  logic       win_clip;
  logic [2:0] win_shift;

  assign shadow_sel = cfg_q[MWD_SEL_MSB:MWD_SEL_LSB];
  assign cnt_en     = cfg_q[MWD_CNTEN_BIT];
  assign win_sel    = cfg_q[MWD_WIN_MSB:MWD_WIN_LSB];
  // codes above 101 all fall on the top window
  assign win_clip   = (win_sel > MWD_WIN_MAX);
  assign win_shift  = win_clip ? MWD_WIN_MAX : win_sel;

  // ----------------------------------------------------------------
  // control outputs
  // ----------------------------------------------------------------
  assign o_detect_count_enable = cnt_en;
  assign o_detector_reset      = det_rst_q;

  // ----------------------------------------------------------------
  // shadow register access
  // ----------------------------------------------------------------
  logic       sel_valid;
  logic       sel_is_count;
  logic [2:0] sel_axis;
  logic [2:0] sel_base;
  logic [2:0] sel_idx;
  logic       bank_wr;
  logic [5:0] shadow_rdata;
  logic [MWD_SHADOWS*MWD_THR_W-1:0] shadow_all;

  // 000 and 100 reach nothing; index 0..2 thresholds, 3..5 counts
  assign sel_valid    = (shadow_sel[1:0] != 2'b00);
  assign sel_is_count = shadow_sel[2];
  assign sel_axis     = {1'b0, shadow_sel[1:0]} - 3'h1;
  assign sel_base     = sel_is_count ? MWD_IDX_COUNT_BASE : 3'h0;
  // out-of-range index reads back zero and writes nowhere
  assign sel_idx      = sel_valid ? (sel_base + sel_axis) : 3'h7;
  assign bank_wr      = wr_shadow && sel_valid;

  mwd_shadow_bank u_bank (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_wr      (bank_wr),
    .i_idx     (sel_idx),
    .i_wdata   (i_reg_wdata[MWD_THR_W-1:0]),
    .o_rdata   (shadow_rdata),
    .o_all     (shadow_all)
  );

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  logic [7:0] rdata_d;

  // the reset bit reads back while its pulse is live
  assign rdata_d = hit_cfg    ? {det_rst_q, cfg_q}
                 : hit_shadow ? {2'b00, shadow_rdata}
                 : MWD_READ_UNMAPPED;

  // registered so the value holds between read strobes
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_reg_rdata <= MWD_READ_UNMAPPED;
    end else if (i_reg_rd) begin
      o_reg_rdata <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // per-axis delta, window, compare and count
  // ----------------------------------------------------------------
  genvar a;
  generate
    for (a = 0; a < MWD_AXES; a++) begin : g_axis
      logic signed [MWD_SAMPLE_W-1:0] cur;
      logic signed [MWD_SAMPLE_W-1:0] prev_q;
      logic                           prev_ok_q;
      logic        [MWD_SAMPLE_W:0]   cur_ext;
      logic        [MWD_SAMPLE_W:0]   prev_ext;
      logic signed [MWD_SAMPLE_W:0]   diff;
      logic                           neg;
      logic        [MWD_SAMPLE_W:0]   mag;
      logic                           sat;
      logic        [MWD_DELTA_W-1:0]  delta;
      logic        [MWD_DELTA_W-1:0]  shifted;
      logic                           above;
      logic        [MWD_THR_W-1:0]    slice;
      logic        [MWD_THR_W-1:0]    thr;
      logic        [MWD_THR_W-1:0]    target;
      logic                           exceed;
      logic                           count_done;
      logic                           wake_set;
      logic                           cnt_step;
      logic        [MWD_THR_W-1:0]    cnt_q;
      logic                           wake_q;

      assign cur      = i_sample[a*MWD_SAMPLE_W +: MWD_SAMPLE_W];
      assign thr      = shadow_all[a*MWD_THR_W +: MWD_THR_W];
      assign target   = shadow_all[(a+MWD_AXES)*MWD_THR_W +: MWD_THR_W];
      // sign-extend both so a full-scale swing cannot wrap
      assign cur_ext  = {cur[MWD_SAMPLE_W-1], cur};
      assign prev_ext = {prev_q[MWD_SAMPLE_W-1], prev_q};
      // moving window: current minus the sample just before it
      assign diff     = cur_ext - prev_ext;
      assign neg      = diff[MWD_SAMPLE_W];
      assign mag      = neg ? (~diff + 13'h0001) : diff;
      // a full-scale swing exceeds 11 bits; saturate rather than wrap
      assign sat      = |mag[MWD_SAMPLE_W:MWD_DELTA_W];
      assign delta    = sat ? {MWD_DELTA_W{1'b1}} : mag[MWD_DELTA_W-1:0];
      assign shifted  = delta >> win_shift;
      assign above    = |shifted[MWD_DELTA_W-1:MWD_THR_W];
      assign slice    = above ? MWD_SLICE_CLAMP : shifted[MWD_THR_W-1:0];
      // threshold 63 is never beaten: the compare is strictly greater
      assign exceed   = i_sample_valid && prev_ok_q && (slice > thr);

      // first sample after reset or re-arm only primes the previous value
      always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          prev_q    <= '0;
          prev_ok_q <= 1'b0;
        end else if (det_rst_q) begin
          prev_ok_q <= 1'b0;
        end else if (i_sample_valid) begin
          prev_q    <= cur;
          prev_ok_q <= 1'b1;
        end
      end

      // ----------------------------------------------------------------
      // per-axis compare and count
      // ----------------------------------------------------------------
      // counting off: the first exceed wakes the axis
      assign count_done = !cnt_en || (cnt_q == target);
      assign wake_set   = exceed && !wake_q && count_done;
      assign cnt_step   = exceed && !wake_q && !count_done;

      // wake stays up until the host re-arms with a detector reset
      always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          cnt_q  <= MWD_SHADOW_RST;
          wake_q <= 1'b0;
        end else if (det_rst_q) begin
          cnt_q  <= MWD_SHADOW_RST;
          wake_q <= 1'b0;
        end else if (wake_set) begin
          wake_q <= 1'b1;
        end else if (cnt_step) begin
          cnt_q  <= cnt_q + 6'h01;
        end
      end

      assign o_axis_wake[a] = wake_q;
    end
  endgenerate
endmodule

/* dv/mwd_motion_wake_chk.sv */
// assertion checker for the motion-wake configuration block
`timescale 1ns/1ps
module mwd_chk
  import mwd_pkg::*;
(
  input wire logic                i_sys_clk,
  input wire logic                i_sys_rst,
  input wire logic [7:0]          i_reg_addr,
  input wire logic                i_reg_wr,
  input wire logic                i_reg_rd,
  input wire logic [7:0]          i_reg_wdata,
  input wire logic [7:0]          o_reg_rdata,
  input wire logic                i_sample_valid,
  input wire logic [MWD_AXES-1:0] o_axis_wake,
  input wire logic                o_detect_count_enable,
  input wire logic                o_detector_reset
);
  // ----------------------------------------------------------------
  // helpers and properties
  // ----------------------------------------------------------------
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  wire logic       cfg_wr  = i_reg_wr && i_reg_addr == MWD_ADDR_CONFIG;
  wire logic       cfg_rd  = i_reg_rd && i_reg_addr == MWD_ADDR_CONFIG;
  wire logic       rst_req = cfg_wr && i_reg_wdata[MWD_DETRST_BIT];
  wire logic       cnt_bit = i_reg_wdata[MWD_CNTEN_BIT];
  wire logic [6:0] wd_lo   = i_reg_wdata[6:0];
  wire logic       map_rd  = i_reg_rd && i_reg_addr != MWD_ADDR_CONFIG
                             && i_reg_addr != MWD_ADDR_SHADOW_DATA;
  chk_rst_from_wr: assert property (rst_req |=> o_detector_reset)
    else $error("detector reset missing after write");
  chk_rst_one_cycle: assert property (o_detector_reset |=> !o_detector_reset)
    else $error("detector reset longer than one cycle");
  chk_rst_has_cause: assert property (o_detector_reset |-> $past(rst_req))
    else $error("detector reset without a write");
  chk_cnten_follows: assert property (cfg_wr |=> o_detect_count_enable == $past(cnt_bit))
    else $error("count enable does not follow write");
  chk_cnten_holds: assert property (!cfg_wr |=> $stable(o_detect_count_enable))
    else $error("count enable changed without write");
  chk_wake_cleared: assert property (o_detector_reset |=> o_axis_wake == '0)
    else $error("wake not cleared by detector reset");
  chk_wake_sticky: assert property (!$past(o_detector_reset) |->
    (o_axis_wake & $past(o_axis_wake)) == $past(o_axis_wake))
    else $error("wake flag dropped without reset");
  chk_wake_cause: assert property ((o_axis_wake & ~$past(o_axis_wake)) != '0
    |-> $past(i_sample_valid))
    else $error("wake rose without a sample");
  chk_unmapped_zero: assert property (map_rd |=> o_reg_rdata == MWD_READ_UNMAPPED)
    else $error("unmapped read not zero");
  chk_config_readback: assert property (cfg_wr ##1 !i_reg_wr ##1 cfg_rd
    |=> o_reg_rdata[6:0] == $past(wd_lo, 3))
    else $error("config readback wrong");
  cover property (rst_req);
  cover property (o_axis_wake[0] && o_detect_count_enable);
  cover property (map_rd);
endmodule

bind mwd_motion_wake mwd_chk chk_u (.i_sys_clk, .i_sys_rst, .i_reg_addr, .i_reg_wr,
  .i_reg_rd, .i_reg_wdata, .o_reg_rdata, .i_sample_valid, .o_axis_wake,
  .o_detect_count_enable, .o_detector_reset);

/* dv/mwd_host_model.sv */
// host-side model driving the configuration register bus
`timescale 1ns/1ps
module mwd_host_model
  import mwd_pkg::*;
(
  input  wire logic       i_sys_clk,
  output logic      [7:0] o_reg_addr,
  output logic            o_reg_wr,
  output logic            o_reg_rd,
  output logic      [7:0] o_reg_wdata,
  input  wire logic [7:0] i_reg_rdata
);
  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  initial begin
    o_reg_addr = 8'h00;
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_wdata = 8'h00;
  end
  // a released bus shows inverted values, never a stale copy
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    o_reg_addr <= a;
    o_reg_wdata <= d;
    o_reg_wr <= 1'b1;
    @(posedge i_sys_clk);
    o_reg_wr <= 1'b0;
    o_reg_addr <= ~a;
    o_reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_sys_clk);
    o_reg_addr <= a;
    o_reg_rd <= 1'b1;
    @(posedge i_sys_clk);
    o_reg_rd <= 1'b0;
    o_reg_addr <= ~a;
    #1;
    d = i_reg_rdata;
  endtask
  task automatic shadow(input logic [2:0] sel, input logic [7:0] v);
    wr(MWD_ADDR_CONFIG, {5'h00, sel});
    wr(MWD_ADDR_SHADOW_DATA, v);
  endtask
  task automatic set_count(input logic [1:0] axis, input int n);
    shadow(3'h5 + 3'(axis), 8'(n - 1));
  endtask
  task automatic rearm(input logic [7:0] cfg);
    wr(MWD_ADDR_CONFIG, cfg | 8'h80);
  endtask
endmodule

/* dv/motion_wake_detect_config_bench.sv */
// self-checking bench for the motion-wake configuration block
`timescale 1ns/1ps
module motion_wake_detect_config_bench import mwd_pkg::*;;
  // ----------------------------------------------------------------
  // signals, design and host
  // ----------------------------------------------------------------
  logic                              i_sys_clk = 1'b0;
  logic                              i_sys_rst = 1'b1;
  logic                              i_sample_valid = 1'b0;
  logic [MWD_AXES*MWD_SAMPLE_W-1:0]  i_sample = '0;
  logic [7:0]                        addr, wdata, rdata, rv;
  logic                              wr, rd, cnt_en, det_rst;
  logic [MWD_AXES-1:0]               wake;
  int                                errors = 0;
  int                                checks = 0;
  int                                cycles = 0;
  always #5 i_sys_clk = ~i_sys_clk;
  mwd_motion_wake dut_u (.i_sys_clk, .i_sys_rst, .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_sample_valid, .i_sample,
    .o_axis_wake(wake), .o_detect_count_enable(cnt_en), .o_detector_reset(det_rst));
  mwd_host_model host_u (.i_sys_clk, .o_reg_addr(addr), .o_reg_wr(wr), .o_reg_rd(rd),
    .o_reg_wdata(wdata), .i_reg_rdata(rdata));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      errors++;
    end
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
    host_u.rd(a, rv);
    chk(n, e, rv);
  endtask
  task automatic smp(input logic [11:0] v);
    @(posedge i_sys_clk);
    i_sample_valid <= 1'b1;
    i_sample <= {v, v, v};
    @(posedge i_sys_clk);
    i_sample_valid <= 1'b0;
    i_sample <= ~{v, v, v};
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // bound well above the few hundred cycles the tests need
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      end_of_test();
    end
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    int sh;
    int d;
    repeat (6) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    rchk("config reset", MWD_ADDR_CONFIG, MWD_CONFIG_RESET);
    rchk("unmapped", 8'h15, MWD_READ_UNMAPPED);
    for (int s = 0; s < 8; s++) begin
      host_u.wr(MWD_ADDR_CONFIG, 8'(s));
      rchk("config", MWD_ADDR_CONFIG, 8'(s));
      host_u.wr(MWD_ADDR_SHADOW_DATA, 8'hc0 | 8'(s * 9));
      rchk("shadow", MWD_ADDR_SHADOW_DATA, (s % 4 == 0) ? 8'h00 : 8'(s * 9));
    end
    $display("shadow test done");
    host_u.shadow(3'h1, 8'h14);
    host_u.shadow(3'h2, 8'h3f);
    host_u.shadow(3'h3, 8'h14);
    // y threshold 63 is never exceeded, so only x and z may wake
    for (int w = 0; w < 8; w++) begin
      sh = (w > 5) ? 5 : w;
      for (int k = 0; k < 3; k++) begin
        d = (k == 0) ? 20 << sh : (k == 1) ? 21 << sh : 1 << (sh + 6);
        host_u.rearm(8'(w << 4));
        smp(12'h000);
        smp(12'(-d));
        repeat (2) @(posedge i_sys_clk);
        #1;
        chk("window wake", (k == 0) ? 8'h00 : 8'h05, 8'(wake));
      end
    end
    $display("window test done");
    host_u.set_count(2'h0, 3);
    host_u.rearm(8'h08);
    #1;
    chk("count enable", 8'h01, 8'(cnt_en));
    chk("detector reset", 8'h01, 8'(det_rst));
    smp(12'h000);
    // z needs 64 events and y never exceeds, so only x wakes
    for (int n = 1; n <= 3; n++) begin
      smp((n % 2) ? 12'h01e : 12'h000);
      repeat (2) @(posedge i_sys_clk);
      #1;
      chk("counted wake", (n == 3) ? 8'h01 : 8'h00, 8'(wake));
    end
    $display("count test done");
    end_of_test();
  end
endmodule
